// ### verilog/link_irq_defines.vh
`ifndef LINK_IRQ_DEFINES_VH
`define LINK_IRQ_DEFINES_VH

`define OFS_LINK_STATE    8'h00
`define OFS_CHANGE_RAW    8'h04
`define OFS_CHANGE_MASKED 8'h08
`define OFS_SELECT_SLOT0  8'h0C
`define OFS_SELECT_SLOT1  8'h10

`define SEL_ADDR_MSB      4
`define SEL_ADDR_LSB      0
`define SEL_IRQ_EN_BIT    6
`define SEL_RESET         32'h00000000
`define LINK_RESET        32'h00000000

`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`define STATUS_REG_ADDR   5'h01
`define LINK_DATA_INDEX   5'h0D
`define HDR_LAST          5'h0C
`define DATA_LAST         5'h0F
`define SKIP_LAST         5'h11
`define OP_READ           2'h2

`endif

// ### verilog/sync2.v
`timescale 1ns/1ps
`default_nettype none
module sync2 (
  input  wire aclk,
  input  wire aresetn,
  input  wire ce,
  input  wire d,
  output reg  q
);
  reg meta_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else if (ce) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // sync2
`default_nettype wire

// ### verilog/event_bit.v
`timescale 1ns/1ps
`default_nettype none
module event_bit (
  input  wire aclk,
  input  wire aresetn,
  input  wire ce,
  input  wire set,
  input  wire clr,
  output reg  q
);
  // Set wins so an event in the clearing cycle survives
  always @(posedge aclk) begin
    if (!aresetn) begin
      q <= 1'b0;
    end else if (ce) begin
      if (set) begin
        q <= 1'b1;
      end else if (clr) begin
        q <= 1'b0;
      end
    end
  end
endmodule // event_bit
`default_nettype wire

// ### verilog/mdio_link_status_irq.v
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "link_irq_defines.vh"
module mdio_link_status_irq (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  input  wire        mdc,
  input  wire        mdio_in,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         link_irq_r
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_HDR  = 3'h1;
  localparam [2:0] ST_TA   = 3'h2;
  localparam [2:0] ST_DATA = 3'h3;
  localparam [2:0] ST_SKIP = 3'h4;

  // Pins come from outside; two flops before use
  wire        mdc_s;
  wire        mdio_s;
  reg         mdc_prev_r;
  reg  [2:0]  state_r;
  reg  [4:0]  cnt_r;
  reg  [12:0] hdr_r;
  reg         ones_r;
  reg         ack_r;
  reg         link_bit_r;
  reg  [4:0]  cur_addr_r;
  reg         upd_r;
  reg  [4:0]  upd_addr_r;
  reg         upd_link_r;
  reg  [31:0] phy_link_state_r;
  reg  [31:0] phy_select_slot0_r;
  reg  [31:0] phy_select_slot1_r;
  wire        slot0_link_event;
  wire        slot1_link_event;
  wire        mdc_rise;
  wire [12:0] hdr_nxt;
  wire [4:0]  sel0_addr;
  wire [4:0]  sel1_addr;
  wire        en0;
  wire        en1;
  wire        change0;
  wire        change1;
  wire [1:0]  link_change_raw;
  wire [1:0]  link_change_masked;
  wire        wr_go;
  wire        clr_raw0;
  wire        clr_raw1;
  reg  [7:0]  aw_addr_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg  [31:0] rd_mux;
  reg         rd_hit;
  reg         wr_hit;

  sync2 u_sync_mdc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       (mdc),
    .q       (mdc_s)
  );

  sync2 u_sync_mdio (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       (mdio_in),
    .q       (mdio_s)
  );

  assign mdc_rise = mdc_s & ~mdc_prev_r;
  assign hdr_nxt  = {hdr_r[11:0], mdio_s};

  // Watch frames on the wire; only generic status reads update state
  always @(posedge aclk) begin
    if (!aresetn) begin
      mdc_prev_r <= 1'b0;
      state_r    <= ST_IDLE;
      cnt_r      <= 5'h00;
      hdr_r      <= 13'h0000;
      ones_r     <= 1'b0;
      ack_r      <= 1'b0;
      link_bit_r <= 1'b0;
      cur_addr_r <= 5'h00;
      upd_r      <= 1'b0;
      upd_addr_r <= 5'h00;
      upd_link_r <= 1'b0;
    end else if (ce) begin
      mdc_prev_r <= mdc_s;
      upd_r      <= 1'b0;
      if (mdc_rise) begin
        case (state_r)
          ST_IDLE: begin
            // Start bit pair is 0 then 1 after idle ones
            if (mdio_s) begin
              ones_r <= 1'b1;
            end else if (ones_r) begin
              ones_r  <= 1'b0;
              cnt_r   <= 5'h00;
              state_r <= ST_HDR;
            end
          end
          ST_HDR: begin
            hdr_r <= hdr_nxt;
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == `HDR_LAST) begin
              cnt_r      <= 5'h00;
              cur_addr_r <= hdr_nxt[9:5];
              if (hdr_nxt[12] && hdr_nxt[11:10] == `OP_READ &&
                  hdr_nxt[4:0] == `STATUS_REG_ADDR) begin
                state_r <= ST_TA;
              end else begin
                // Unrelated frame; skip it so data cannot fake a start
                state_r <= ST_SKIP;
              end
            end
          end
          ST_TA: begin
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == 5'h01) begin
              // Silent PHY leaves the pulled-up line high
              ack_r   <= ~mdio_s;
              cnt_r   <= 5'h00;
              state_r <= ST_DATA;
            end
          end
          ST_DATA: begin
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == `LINK_DATA_INDEX) begin
              link_bit_r <= mdio_s;
            end
            if (cnt_r == `DATA_LAST) begin
              upd_r      <= 1'b1;
              upd_addr_r <= cur_addr_r;
              upd_link_r <= ack_r & link_bit_r;
              state_r    <= ST_IDLE;
            end
          end
          ST_SKIP: begin
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == `SKIP_LAST) begin
              state_r <= ST_IDLE;
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Only the frame observer writes this; bus writes never reach it
  always @(posedge aclk) begin
    if (!aresetn) begin
      phy_link_state_r <= `LINK_RESET;
    end else if (ce && upd_r) begin
      phy_link_state_r[upd_addr_r] <= upd_link_r;
    end
  end

  assign sel0_addr = phy_select_slot0_r[`SEL_ADDR_MSB:`SEL_ADDR_LSB];
  assign sel1_addr = phy_select_slot1_r[`SEL_ADDR_MSB:`SEL_ADDR_LSB];
  assign en0       = phy_select_slot0_r[`SEL_IRQ_EN_BIT];
  assign en1       = phy_select_slot1_r[`SEL_IRQ_EN_BIT];
  assign change0   = upd_r && upd_addr_r == sel0_addr &&
                     phy_link_state_r[upd_addr_r] != upd_link_r;
  assign change1   = upd_r && upd_addr_r == sel1_addr &&
                     phy_link_state_r[upd_addr_r] != upd_link_r;

  // Write-one-to-clear through either view clears the raw event
  assign wr_go    = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign clr_raw0 = wr_go && w_strb_r[0] && w_data_r[0] &&
                    (aw_addr_r == `OFS_CHANGE_RAW ||
                     aw_addr_r == `OFS_CHANGE_MASKED);
  assign clr_raw1 = wr_go && w_strb_r[0] && w_data_r[1] &&
                    (aw_addr_r == `OFS_CHANGE_RAW ||
                     aw_addr_r == `OFS_CHANGE_MASKED);

  event_bit u_ev0 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .set     (change0),
    .clr     (clr_raw0),
    .q       (slot0_link_event)
  );

  event_bit u_ev1 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .set     (change1),
    .clr     (clr_raw1),
    .q       (slot1_link_event)
  );

  assign link_change_raw    = {slot1_link_event, slot0_link_event};
  assign link_change_masked = link_change_raw & {en1, en0};

  always @(posedge aclk) begin
    if (!aresetn) begin
      link_irq_r <= 1'b0;
    end else if (ce) begin
      link_irq_r <= |link_change_masked;
    end
  end

  // Read decode
  always @* begin
    rd_hit = 1'b1;
    rd_mux = 32'h00000000;
    case (s_axi_araddr)
      `OFS_LINK_STATE:    rd_mux = phy_link_state_r;
      `OFS_CHANGE_RAW:    rd_mux = {30'h00000000, link_change_raw};
      `OFS_CHANGE_MASKED: rd_mux = {30'h00000000, link_change_masked};
      `OFS_SELECT_SLOT0:  rd_mux = phy_select_slot0_r;
      `OFS_SELECT_SLOT1:  rd_mux = phy_select_slot1_r;
      default:            rd_hit = 1'b0;
    endcase
  end

  always @* begin
    case (aw_addr_r)
      `OFS_LINK_STATE:    wr_hit = 1'b1;
      `OFS_CHANGE_RAW:    wr_hit = 1'b1;
      `OFS_CHANGE_MASKED: wr_hit = 1'b1;
      `OFS_SELECT_SLOT0:  wr_hit = 1'b1;
      `OFS_SELECT_SLOT1:  wr_hit = 1'b1;
      default:            wr_hit = 1'b0;
    endcase
  end

  // Write channel: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready      <= 1'b1;
      s_axi_wready       <= 1'b1;
      s_axi_bvalid       <= 1'b0;
      s_axi_bresp        <= `RESP_OKAY;
      aw_addr_r          <= 8'h00;
      w_data_r           <= 32'h00000000;
      w_strb_r           <= 4'h0;
      phy_select_slot0_r <= `SEL_RESET;
      phy_select_slot1_r <= `SEL_RESET;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        // Only the documented fields are writable; rest stays zero
        if (aw_addr_r == `OFS_SELECT_SLOT0 && w_strb_r[0]) begin
          phy_select_slot0_r[`SEL_ADDR_MSB:`SEL_ADDR_LSB] <= w_data_r[4:0];
          phy_select_slot0_r[`SEL_IRQ_EN_BIT] <= w_data_r[6];
        end
        if (aw_addr_r == `OFS_SELECT_SLOT1 && w_strb_r[0]) begin
          phy_select_slot1_r[`SEL_ADDR_MSB:`SEL_ADDR_LSB] <= w_data_r[4:0];
          phy_select_slot1_r[`SEL_IRQ_EN_BIT] <= w_data_r[6];
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read channel: one outstanding read, data captured at the handshake
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // mdio_link_status_irq
`default_nettype wire

// ### bench/phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module phy_model (
  output logic mdc,
  output logic mdio_in
);
  initial begin
    mdc = 1'b0;
    mdio_in = 1'b1;
  end
  // Clock stands low between frames; pull-up keeps idle line high
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic ack, input logic [15:0] d);
    logic [33:0] b;
    b = {4'hD, op, pa, ra, 1'b1, ~ack, d};
    #1;
    for (int i = 33; i >= 0; i--) begin
      mdio_in = b[i];
      #32 mdc = 1'b1;
      #32 mdc = 1'b0;
    end
    mdio_in = 1'b1;
  endtask
endmodule // phy_model
`default_nettype wire

// ### bench/link_irq_sva.sv
`timescale 1ns/1ps
`default_nettype none
module link_irq_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        link_irq_r
);
  logic [7:0] aw_r;
  logic [7:0] ar_r;
  logic [1:0] wd_r;
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) aw_r <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata[1:0];
    if (s_axi_arvalid && s_axi_arready) ar_r <= s_axi_araddr;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  chk_event_upper_zero: assert property (s_axi_rvalid && (ar_r == 8'h04 || ar_r == 8'h08)
    |-> s_axi_rdata[31:2] == 30'h0) else $error("event upper bits set");
  chk_link_ro_okay: assert property (s_axi_bvalid && aw_r == 8'h00 |-> s_axi_bresp == 2'h0)
    else $error("link state write refused");
  chk_w1c_irq_low: assert property (s_axi_bvalid && s_axi_bready && aw_r == 8'h04 &&
    wd_r == 2'h3 |-> ##[0:3] !link_irq_r) else $error("irq stays after clear");
  chk_irq_masked: assert property ($rose(s_axi_rvalid) && ar_r == 8'h08
    |-> link_irq_r == |s_axi_rdata[1:0]) else $error("irq differs from masked");
endmodule // link_irq_sva
bind mdio_link_status_irq link_irq_sva link_irq_sva_i (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .link_irq_r);
`default_nettype wire

// ### bench/mdio_link_status_irq_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mdio_link_status_irq_tb;
  logic        aclk, aresetn, ce, mdc, mdio_in, link_irq_r;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, link, sel0, sel1, seed, r, d;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, raw;
  int          fail_count, n_compared, cyc;
  phy_model phy_model_i (.mdc, .mdio_in);
  mdio_link_status_irq mdio_link_status_irq_i (.aclk, .aresetn, .ce, .mdc, .mdio_in,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_irq_r);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  function automatic logic [31:0] mdl(input logic [7:0] a);
    case (a)
      8'h00: return link;
      8'h04: return {30'h0, raw};
      8'h08: return {30'h0, raw & {sel1[6], sel0[6]}};
      8'h0C: return sel0;
      8'h10: return sel1;
      default: return 32'h0;
    endcase
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic pa, pw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && s_axi_awready === 1'b1) begin
        pa = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (pw && s_axi_wready === 1'b1) begin
        pw = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", a > 8'h10 ? 32'h2 : 32'h0, {30'h0, s_axi_bresp});
    if (a == 8'h04 || a == 8'h08) raw = raw & ~v[1:0];
    if (a == 8'h0C) sel0 = v & 32'h5F;
    if (a == 8'h10) sel1 = v & 32'h5F;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", mdl(a), s_axi_rdata);
    chk("rresp", a > 8'h10 ? 32'h2 : 32'h0, {30'h0, s_axi_rresp});
    chk("irq", {31'h0, |(raw & {sel1[6], sel0[6]})}, {31'h0, link_irq_r});
  endtask
  // Fixed wait covers the two-flop sampling of both link pins
  task automatic frm(input logic [4:0] pa, input logic [1:0] op, input logic [4:0] ra,
                     input logic ack, input logic [15:0] v);
    logic b;
    phy_model_i.frame(op, pa, ra, ack, v);
    repeat (12) @(posedge aclk);
    b = ack & v[2];
    if (op == 2'b10 && ra == 5'h01) begin
      if (b != link[pa] && pa == sel0[4:0]) raw[0] = 1'b1;
      if (b != link[pa] && pa == sel1[4:0]) raw[1] = 1'b1;
      link[pa] = b;
    end
  endtask
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, aresetn, cyc, fail_count, n_compared} = '0;
    s_axi_wstrb = 4'hF;
    ce = 1'b1;
    seed = 32'h8817B23E;
    {link, sel0, sel1, raw} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a <= 20; a += 4) rd(a[7:0]);
    $display("test reset done");
    wr(8'h00, 32'hFFFFFFFF);
    wr(8'h14, 32'hFFFFFFFF);
    rd(8'h00);
    $display("test access done");
    wr(8'h0C, 32'hFFFFFF43);
    wr(8'h10, 32'h00000011);
    // Frozen block must miss a whole status frame; a leak would raise event 0
    ce <= 1'b0;
    phy_model_i.frame(2'b10, 5'h03, 5'h01, 1'b1, 16'hFFFF);
    @(posedge aclk);
    ce <= 1'b1;
    rd(8'h00);
    rd(8'h04);
    $display("test freeze done");
    for (int k = 0; k < 40; k++) begin
      r = $random(seed);
      d = $random(seed);
      frm(r[1:0] == 2'h0 ? r[6:2] : (r[0] ? 5'd3 : 5'd17), r[10:8] == 3'h0 ? 2'b01 : 2'b10,
          r[13:11] == 3'h0 ? r[20:16] : 5'h01, r[21] | r[22], d[15:0]);
      rd(8'h00);
      rd(8'h04);
      rd(8'h08);
      if (r[23]) wr(r[24] ? 8'h08 : 8'h04, d);
      if (r[25]) wr(8'h0C, {25'h0, r[26], 1'b0, 5'd3});
      if (r[27]) wr(8'h10, {25'h0, r[28], 1'b0, 5'd17});
      rd(8'h08);
    end
    $display("test link events done");
    // Reset in mid-run must clear link state, events and slots
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    {link, sel0, sel1, raw} = '0;
    for (int a = 0; a <= 20; a += 4) rd(a[7:0]);
    $display("test mid reset done");
    complete_run();
  end
endmodule // mdio_link_status_irq_tb
`default_nettype wire
